// ===== verilog/primary_timer.sv
// Sixteen-bit timer with prescaler, buffered access and APB register slave
`timescale 1ns/1ps
`default_nettype none
module primary_timer (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic por_bor_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clk_in,
  input wire logic osc_clk_in,
  input wire logic event_trig_a,
  input wire logic event_trig_b,
  output logic osc_enable,
  output logic time_base_a,
  output logic time_base_b,
  output logic irq
);
  import timer_pkg::*;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] count_low_reg;
  logic [7:0] count_high_reg;
  logic [7:0] high_latch_reg;
  logic [7:0] control_reg;
  logic [PRESCALE_W-1:0] prescale_reg;
  logic status_reg;
  logic mask_reg;
  logic [1:0] base_sel_reg;
  logic irq_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [1:0] count_valid_reg;
  logic [7:0] count_low_next;
  logic [7:0] count_high_next;
  logic [PRESCALE_W-1:0] prescale_next;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire setup_ph = psel & ~penable;
  // Writes land only at the access edge that completes the transfer
  wire access_done = psel & penable & pready_reg;
  wire wr_ph = access_done & pwrite & pstrb[0];
  wire hit_low = paddr == OFS_COUNT_LOW;
  wire hit_high = paddr == OFS_COUNT_HIGH;
  wire hit_ctrl = paddr == OFS_CONTROL;
  wire hit_stat = paddr == OFS_STATUS;
  wire hit_mask = paddr == OFS_MASK;
  wire hit_base = paddr == OFS_BASE_SEL;
  wire mapped = hit_low | hit_high | hit_ctrl | hit_stat | hit_mask | hit_base;
  wire wr_low = wr_ph & hit_low;
  wire wr_high = wr_ph & hit_high;
  wire buffered = control_reg[BIT_BUFFERED];
  // Buffered high write only fills the latch
  wire wr_high_direct = wr_high & ~buffered; // [R6]
  wire count_write = wr_low | wr_high_direct;

  // ------------------------------------------------------------
  // Clock source and prescale
  // ------------------------------------------------------------
  logic ext_rise;
  edge_sync u_ext (
    .core_clk(core_clk),
    .rstn(rstn),
    .din(control_reg[BIT_OSC_ENABLE] ? osc_clk_in : ext_clk_in),
    .rise(ext_rise)
  );
  // Source select: internal clock every cycle, else synchronised pin edge [R10]
  wire src_tick = control_reg[BIT_CLOCK_SOURCE] ? ext_rise : 1'b1;
  wire running = control_reg[BIT_TIMER_ON]; // [R11]
  wire [1:0] ps_sel = control_reg[BIT_PRESCALE_HI:BIT_PRESCALE_LO];
  // 00 1:1, 01 1:2, 10 1:4, 11 1:8 [R17]
  wire [PRESCALE_W-1:0] ps_max = PRESCALE_W'((4'd1 << ps_sel) - 4'd1);
  wire ps_wrap = prescale_reg == ps_max;
  wire inc = running & src_tick & ps_wrap;
  wire [16:0] count_inc = {1'b0, count_high_reg, count_low_reg} + 17'h0_0001;
  wire overflow = inc & count_inc[16];

  // Special event reset only from units using this timer as base [R3] [R4]
  wire evt_reset = (event_trig_a & ~base_sel_reg[BIT_ALT_FOR_A]) |
                   (event_trig_b & ~base_sel_reg[BIT_ALT_FOR_B]);

  always_comb begin
    prescale_next = prescale_reg;
    if (running & src_tick)
      prescale_next = ps_wrap ? '0 : prescale_reg + PRESCALE_W'(1);
    if (count_write)
      prescale_next = '0; // [R5] [R6]
  end

  always_comb begin
    count_low_next = count_low_reg;
    count_high_next = count_high_reg;
    if (inc) begin
      count_low_next = count_inc[7:0]; // [R11]
      count_high_next = count_inc[15:8];
    end
    if (evt_reset) begin
      count_low_next = 8'h00; // [R1]
      count_high_next = 8'h00;
    end
    // Software write overrides trigger [R14]
    if (wr_low) begin
      count_low_next = pwdata[7:0];
      if (buffered)
        count_high_next = high_latch_reg; // [R16]
    end
    if (wr_high_direct)
      count_high_next = pwdata[7:0];
  end

  // ------------------------------------------------------------
  // Count bytes: no reset, power-up value unknown [R1] [R8] [R9]
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    count_low_reg <= count_low_next;
    count_high_reg <= count_high_next;
  end

  always_ff @(posedge core_clk) begin
    if (wr_high & buffered)
      high_latch_reg <= pwdata[7:0]; // [R6]
  end

  // ------------------------------------------------------------
  // Control register: cleared only by power-on / brown-out [R2]
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge por_bor_n) begin
    if (!por_bor_n)
      control_reg <= CONTROL_RESET; // [R2]
    else if (wr_ph & hit_ctrl)
      control_reg <= pwdata[7:0] & CONTROL_WMASK; // [R7]
  end

  // Marks count bytes that hold a defined value, for the checks below
  always_ff @(posedge core_clk or negedge por_bor_n) begin
    if (!por_bor_n) begin
      count_valid_reg <= 2'b00;
    end else begin
      if (wr_low | evt_reset)
        count_valid_reg[0] <= 1'b1;
      if (wr_high_direct | evt_reset | (wr_low & buffered))
        count_valid_reg[1] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prescale_reg <= '0;
      status_reg <= 1'b0;
      mask_reg <= 1'b0;
      base_sel_reg <= 2'b00;
      irq_reg <= 1'b0;
      osc_enable <= 1'b0;
      time_base_a <= 1'b1;
      time_base_b <= 1'b1;
    end else begin
      prescale_reg <= prescale_next;
      // Set wins over write-one clear; trigger never sets it [R12] [R15]
      status_reg <= overflow | (status_reg & ~(wr_ph & hit_stat & pwdata[BIT_OVERFLOW]));
      if (wr_ph & hit_mask)
        mask_reg <= pwdata[BIT_OVERFLOW];
      if (wr_ph & hit_base)
        base_sel_reg <= pwdata[1:0]; // [R3]
      irq_reg <= status_reg & mask_reg;
      osc_enable <= control_reg[BIT_OSC_ENABLE];
      time_base_a <= ~base_sel_reg[BIT_ALT_FOR_A];
      time_base_b <= ~base_sel_reg[BIT_ALT_FOR_B];
    end
  end

  // ------------------------------------------------------------
  // APB answer: ready in the access cycle, one wait-free cycle
  // ------------------------------------------------------------
  wire [7:0] rd_byte = hit_low ? count_low_reg :
                       hit_high ? count_high_reg :
                       hit_ctrl ? control_reg :
                       hit_stat ? {7'h00, status_reg} :
                       hit_mask ? {7'h00, mask_reg} :
                       hit_base ? {6'h00, base_sel_reg} : 8'h00;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup_ph;
      pslverr_reg <= setup_ph & ~mapped;
      if (setup_ph & ~pwrite)
        prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_ctrl_bit6;
    @(posedge core_clk) disable iff (!rstn) control_reg[6] == 1'b0;
  endproperty
  a_ctrl_bit6: assert property (p_ctrl_bit6) else $error("control bit 6 set"); // [R7]

  property p_stopped;
    @(posedge core_clk) disable iff (!rstn)
      (&count_valid_reg && !running && !evt_reset && !count_write) |=> $stable({count_high_reg, count_low_reg});
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while stopped"); // [R10]

  property p_evt_clear;
    @(posedge core_clk) disable iff (!rstn)
      (evt_reset && !count_write) |=> {count_high_reg, count_low_reg} == 16'h0000;
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("trigger did not clear count"); // [R1]

  property p_deselect;
    @(posedge core_clk) disable iff (!rstn)
      (count_valid_reg[0] && base_sel_reg == 2'b11 && !running && !count_write) |=> $stable(count_low_reg);
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselected trigger changed count"); // [R4]

  property p_write_wins;
    @(posedge core_clk) disable iff (!rstn) (wr_low && evt_reset) |=> count_low_reg == $past(pwdata[7:0]);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("trigger beat write"); // [R14]

  property p_ps_clear;
    @(posedge core_clk) disable iff (!rstn) wr_low |=> prescale_reg == '0;
  endproperty
  a_ps_clear: assert property (p_ps_clear) else $error("prescaler not cleared"); // [R5]

  property p_buf_high;
    @(posedge core_clk) disable iff (!rstn)
      (wr_high && buffered && !inc && !evt_reset) |=> $stable(count_high_reg);
  endproperty
  a_buf_high: assert property (p_buf_high) else $error("buffered high write hit count"); // [R6]

  property p_latch_xfer;
    @(posedge core_clk) disable iff (!rstn) (wr_low && buffered) |=> count_high_reg == $past(high_latch_reg);
  endproperty
  a_latch_xfer: assert property (p_latch_xfer) else $error("latch not transferred"); // [R16]

  property p_ovf_flag;
    @(posedge core_clk) disable iff (!rstn) overflow |=> status_reg;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set"); // [R12]

  property p_no_evt_flag;
    @(posedge core_clk) disable iff (!rstn) (!status_reg && !overflow) |=> !status_reg;
  endproperty
  a_no_evt_flag: assert property (p_no_evt_flag) else $error("flag set without overflow"); // [R15]

  c_overflow: cover property (@(posedge core_clk) disable iff (!rstn) overflow);
  c_evt: cover property (@(posedge core_clk) disable iff (!rstn) evt_reset && running);
  c_buf_write: cover property (@(posedge core_clk) disable iff (!rstn) wr_low && buffered);
  c_irq: cover property (@(posedge core_clk) disable iff (!rstn) irq_reg);
endmodule // primary_timer
`default_nettype wire

// ===== shared/timer_pkg.sv
// Constants and register map of the sixteen-bit timer with prescaler
// Functional notes
// (R1) Count bytes survive every device reset; only special event trigger clears them.
// (R2) Control register becomes 00h on power-on or brown-out reset only.
// (R3) Timer is default time base of both compare units; alternate timer may substitute.
// (R4) A deselected unit's compare-triggered reset leaves this count unchanged.
// (R5) Any write to low or high count byte clears the prescaler counter; in buffered mode a high write here leaves it unchanged.
// (R6) Buffered mode: high write only loads latch; only low write clears prescaler.
// (R7) Control layout: buffered, zero, prescale[1:0], osc, sync, source, timer on.
// (R8) Low count byte unknown after power-on or brown-out, else unchanged.
// (R9) High count byte unknown after power-on or brown-out, else unchanged.
// (R10) Control zero stops timer, internal clock, oscillator off, prescale 1:1.
// (R11) Setting timer on counts up from current value with chosen clock and prescale.
// (R12) Overflow sets the flag; software polls it and clears it itself.
// (R13) Software should not write low byte while running; high byte shortens interval.
// (R14) A software count write coinciding with special event reset wins.
// (R15) Special event reset of the count does not set the overflow flag.
// (R16) Buffered mode: low write moves the high latch into count high byte.
// (R17) Prescale select 00 1:1, 01 1:2, 10 1:4, 11 1:8.
package timer_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_COUNT_LOW = 8'h00;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_BASE_SEL = 8'h14;

  // ------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------
  localparam int BIT_BUFFERED = 7;
  localparam int BIT_PRESCALE_HI = 5;
  localparam int BIT_PRESCALE_LO = 4;
  localparam int BIT_OSC_ENABLE = 3;
  localparam int BIT_SYNC_SELECT_N = 2;
  localparam int BIT_CLOCK_SOURCE = 1;
  localparam int BIT_TIMER_ON = 0;
  localparam logic [7:0] CONTROL_WMASK = 8'hBF;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Status / mask bit and time base select bits
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_ALT_FOR_A = 0;
  localparam int BIT_ALT_FOR_B = 1;

  // Prescaler counter width covers 1:8
  localparam int PRESCALE_W = 3;

endpackage : timer_pkg

// ===== verilog/edge_sync.sv
// Two-flop synchroniser with rising edge pulse on the synchronised level
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic din,
  output logic rise
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~last_reg;
endmodule // edge_sync
`default_nettype wire

// ===== test/testbench.sv
// Self-checking testbench for the sixteen-bit timer with prescaler
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import timer_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic por_bor_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic ext_clk_in = 1'b0;
  logic osc_clk_in = 1'b0;
  logic p;
  int e;
  logic event_trig_a = 1'b0;
  logic event_trig_b = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, osc_enable, time_base_a, time_base_b, irq, serr;
  logic [31:0] rdat;
  logic [15:0] rnd = 16'h0034;
  logic [7:0] v;
  int err_total = 0;
  int n_compared = 0;
  int n;
  always #2.5 core_clk = ~core_clk;
  primary_timer dut (.core_clk(core_clk), .rstn(rstn), .por_bor_n(por_bor_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in),
    .osc_clk_in(osc_clk_in), .event_trig_a(event_trig_a), .event_trig_b(event_trig_b),
    .osc_enable(osc_enable), .time_base_a(time_base_a), .time_base_b(time_base_b), .irq(irq));
  // ------------------------------------------------------------
  // Bus, compare and expectation helpers
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] next_rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Count after 67 cycles of counting, two ticks of slack either side for pipelining
  function automatic logic near(input logic [7:0] c, input int k);
    return int'(c) >= (67 >> k) - 2 && int'(c) <= (67 >> k) + 2;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      t++;
    end while (pready !== 1'b1 && t < 16);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 16) begin
      err_total++;
      give_verdict();
    end
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    apb(1'b0, a, 8'h00);
    chk(what, rdat, {24'h00_0000, e});
  endtask
  task automatic pulse_reset(input logic por);
    rstn <= 1'b0;
    por_bor_n <= ~por;
    cyc(3);
    rstn <= 1'b1;
    por_bor_n <= 1'b1;
    cyc(1);
  endtask
  task automatic trig(input logic b);
    event_trig_a <= ~b;
    event_trig_b <= b;
    cyc(1);
    event_trig_a <= 1'b0;
    event_trig_b <= 1'b0;
    cyc(3);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(5);
    rstn <= 1'b1;
    por_bor_n <= 1'b1;
    cyc(1);
    rd(OFS_CONTROL, 8'h00, "ctl reset");
    chk("bases", 32'({time_base_a, time_base_b}), 32'h0000_0003);
    for (int i = 0; i < 6; i++) begin
      rnd = next_rnd(rnd);
      v = {rnd[7:1], 1'b0};
      wr(OFS_CONTROL, v);
      rd(OFS_CONTROL, v & CONTROL_WMASK, "ctl rw");
      chk("osc", 32'(osc_enable), 32'(v[3]));
    end
    wr(OFS_CONTROL, 8'h30);
    wr(OFS_COUNT_LOW, rnd[7:0]);
    wr(OFS_COUNT_HIGH, rnd[15:8]);
    pulse_reset(1'b0);
    rd(OFS_COUNT_LOW, rnd[7:0], "low kept");
    rd(OFS_COUNT_HIGH, rnd[15:8], "high kept");
    rd(OFS_CONTROL, 8'h30, "ctl kept");
    pulse_reset(1'b1);
    rd(OFS_CONTROL, 8'h00, "ctl por");
    chk("osc off", 32'(osc_enable), 32'h0000_0000);
    wr(OFS_BASE_SEL, 8'h01);
    cyc(1);
    chk("base a off", 32'({time_base_a, time_base_b}), 32'h0000_0001);
    trig(1'b0);
    rd(OFS_COUNT_HIGH, rnd[15:8], "trig a ignored");
    trig(1'b1);
    rd(OFS_COUNT_HIGH, 8'h00, "trig b clears");
    wr(OFS_BASE_SEL, 8'h00);
    fork
      wr(OFS_COUNT_LOW, 8'h5a);
      begin
        cyc(1);
        trig(1'b0);
      end
    join
    rd(OFS_COUNT_LOW, 8'h5a, "write wins");
    wr(OFS_BASE_SEL, 8'h03);
    cyc(1);
    chk("bases off", 32'({time_base_a, time_base_b}), 32'h0000_0000);
    trig(1'b0);
    trig(1'b1);
    rd(OFS_COUNT_LOW, 8'h5a, "deselected");
    wr(OFS_BASE_SEL, 8'h00);
    wr(OFS_COUNT_HIGH, 8'hff);
    wr(OFS_COUNT_LOW, 8'hf0);
    trig(1'b0);
    rd(OFS_COUNT_LOW, 8'h00, "trig clears");
    rd(OFS_STATUS, 8'h00, "no flag on trig");
    wr(OFS_MASK, 8'h00);
    wr(OFS_COUNT_HIGH, 8'hff);
    wr(OFS_COUNT_LOW, 8'hf8);
    wr(OFS_CONTROL, 8'h01);
    n = 0;
    rdat = 32'h0000_0000;
    while (rdat[0] !== 1'b1 && n < 20) begin
      apb(1'b0, OFS_STATUS, 8'h00);
      n++;
    end
    chk("ovf flag", 32'(rdat[0]), 32'h0000_0001);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_MASK, 8'h01);
    cyc(2);
    chk("irq", 32'(irq), 32'h0000_0001);
    wr(OFS_STATUS, 8'h01);
    cyc(2);
    chk("irq clr", 32'(irq), 32'h0000_0000);
    rd(OFS_STATUS, 8'h00, "flag clr");
    wr(OFS_COUNT_LOW, 8'h11);
    wr(OFS_COUNT_HIGH, 8'h22);
    wr(OFS_CONTROL, 8'h80);
    wr(OFS_COUNT_HIGH, 8'h77);
    rd(OFS_COUNT_LOW, 8'h11, "latch only");
    rd(OFS_COUNT_HIGH, 8'h22, "high held");
    wr(OFS_COUNT_LOW, 8'h33);
    wr(OFS_CONTROL, 8'h00);
    rd(OFS_COUNT_HIGH, 8'h77, "latch moved");
    rd(OFS_COUNT_LOW, 8'h33, "low loaded");
    for (int k = 0; k < 4; k++) begin
      wr(OFS_COUNT_HIGH, 8'h00);
      wr(OFS_COUNT_LOW, 8'h00);
      wr(OFS_CONTROL, 8'((k << 4) | 1));
      cyc(64);
      wr(OFS_CONTROL, 8'h00);
      apb(1'b0, OFS_COUNT_LOW, 8'h00);
      chk("rate", 32'(near(rdat[7:0], k)), 32'h0000_0001);
    end
    for (int m = 0; m < 2; m++) begin
      wr(OFS_COUNT_HIGH, 8'h00);
      wr(OFS_COUNT_LOW, 8'h00);
      ext_clk_in <= 1'b0;
      osc_clk_in <= 1'b0;
      wr(OFS_CONTROL, (m == 1) ? 8'h0b : 8'h03);
      e = 0;
      p = 1'b0;
      for (int j = 0; j < 40; j++) begin
        rnd = next_rnd(rnd);
        e += int'(rnd[0] & ~p);
        p = rnd[0];
        ext_clk_in <= (m == 1) ? rnd[1] : rnd[0];
        osc_clk_in <= (m == 1) ? rnd[0] : rnd[1];
        cyc(1);
      end
      ext_clk_in <= 1'b0;
      osc_clk_in <= 1'b0;
      cyc(4);
      wr(OFS_CONTROL, 8'h00);
      apb(1'b0, OFS_COUNT_LOW, 8'h00);
      chk("pin count", rdat, 32'(e));
    end
    wr(8'h18, 8'hff);
    chk("unmapped wr", 32'(serr), 32'h0000_0001);
    apb(1'b0, 8'h18, 8'h00);
    chk("unmapped rd", 32'({serr, rdat[7:0]}), 32'h0000_0100);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
